/* design/mbbd_cfg.svh */
// timing and encoding constants for the move, branch and bit decoder
// Contract
// - e8-ef register to accumulator 1 byte 1 cycle; e6-e7 indirect load 1 byte 2 cycles
// - 74 immediate and e5 direct to accumulator, two bytes, two cycles each
// - f8-ff 1b/2c, a8-af 2b/4c, 78-7f 2b/2c register destination moves
// - 85 3b/4c, 88-8f 2b/3c, f5 2b/3c direct destination moves
// - 86-87 indirect to direct 2b/4c; 75 immediate to direct 3b/3c
// - f6-f7 1b/3c, a6-a7 2b/5c, 76-77 2b/3c indirect destination moves
// - 90 loads data pointer from two immediate bytes, 3b/3c
// - 93 and 83 code byte loads, one byte, three cycles
// - external reads e0,e2-e3 1b/4c; writes f0,f2-f3 1b/5c
// - external data moves pick one of two actions by program-write select bit
// - c0 push 2b/4c; d0 pop 2b/3c
// - exchanges c8-cf 2c, c5 and c6-c7 3c, d6-d7 3c
// - absolute call xxx10001 2b/6c; long call 12 3b/6c
// - absolute jump xxx00001 2b/3c; 02 3b/4c; 80 2b/3c
// - 73 jumps to accumulator plus data pointer, 1b/2c
// - 60,70,40,50 conditional relative branches, 2b/3c
// - 20,30,10 bit test branches 3b/4c, 10 also clears the bit
// - compare branch unequal b4,b5,b6-bf all 3b/4c
// - d8-df 2b/3c, d5 3b/4c, nop 00 1b/1c
// - carry clr/set/cpl c3,d3,b3 1b/1c; bit forms c2,d2,b2 2b/3c
// - 82,72,b0,a0 bit logic into carry, 2b/2c
// - a2 bit to carry 2b/2c; 92 carry to bit 2b/3c
`ifndef MBBD_CFG_SVH
`define MBBD_CFG_SVH
`define MBBD_PWS_BIT 4
`define MBBD_RESET_OPC 8'h00
`define MBBD_MAX_CYC 6
// execution lengths in core cycles, sized to the decoded cycles field
`define MBBD_CYC_1 3'd1
`define MBBD_CYC_2 3'd2
`define MBBD_CYC_3 3'd3
`define MBBD_CYC_4 3'd4
`define MBBD_CYC_5 3'd5
`define MBBD_CYC_6 3'd6
`endif

/* design/mbbd_pkg.sv */
// types shared by the move, branch and bit decoder
package mbbd_pkg;
   typedef enum logic [4:0] {
      MBBD_OP_NONE, MBBD_OP_MOV_ACC, MBBD_OP_MOV_REG, MBBD_OP_MOV_DIR, MBBD_OP_MOV_IND,
      MBBD_OP_LOAD_DATA_POINTER, MBBD_OP_CODE_LOAD, MBBD_OP_EXT_READ, MBBD_OP_EXT_WRITE,
      MBBD_OP_PUSH, MBBD_OP_POP, MBBD_OP_XCH, MBBD_OP_NIBBLE_XCH, MBBD_OP_CALL,
      MBBD_OP_JUMP, MBBD_OP_JUMP_IND, MBBD_OP_COND_BR, MBBD_OP_BIT_BR, MBBD_OP_CMP_BR,
      MBBD_OP_DEC_BR, MBBD_OP_NOP, MBBD_OP_CARRY_OP, MBBD_OP_BIT_OP, MBBD_OP_BIT_LOGIC,
      MBBD_OP_BIT_MOVE
   } mbbd_class_type;
   typedef struct packed {
      logic known;
      mbbd_class_type op_class;
      logic [1:0] bytes;
      logic [2:0] cycles;
      logic ext_move;
      logic ext_alt;
   } mbbd_dec_type;
   typedef enum logic [1:0] {MBBD_ST_FETCH, MBBD_ST_EXEC} mbbd_state_type;
endpackage : mbbd_pkg

/* design/mbbd_decoder.sv */
// opcode decode and cycle sequencing for moves, branches and bit operations
`timescale 1ns/100ps
`default_nettype none
`include "mbbd_cfg.svh"
module mbbd_decoder
   import mbbd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic opc_valid,
   input wire logic [7:0] opc,
   input wire logic [7:0] power_ctrl,
   output logic fetch_ready,
   output logic instr_done,
   output mbbd_dec_type dec_out,
   output logic [2:0] cycle_left
);
   ////////////////////////////////////////////////////////////////
   function automatic mbbd_dec_type mk(input mbbd_class_type c, input logic [1:0] b,
                                       input logic [2:0] n);
      mbbd_dec_type d;
      d = '0;
      d.known = 1'b1;
      d.op_class = c;
      d.bytes = b;
      d.cycles = n;
      return d;
   endfunction : mk

   // data transfer group
   function automatic mbbd_dec_type dec_move(input logic [7:0] o);
      mbbd_dec_type d;
      d = '0;
      unique case (o) inside
         [8'he8:8'hef]: begin
            d = mk(MBBD_OP_MOV_ACC, 2'd1, `MBBD_CYC_1);
         end
         [8'he6:8'he7]: begin
            d = mk(MBBD_OP_MOV_ACC, 2'd1, `MBBD_CYC_2);
         end
         8'h74: begin
            d = mk(MBBD_OP_MOV_ACC, 2'd2, `MBBD_CYC_2);
         end
         8'he5: begin
            d = mk(MBBD_OP_MOV_ACC, 2'd2, `MBBD_CYC_2);
         end
         [8'hf8:8'hff]: begin
            d = mk(MBBD_OP_MOV_REG, 2'd1, `MBBD_CYC_2);
         end
         [8'ha8:8'haf]: begin
            d = mk(MBBD_OP_MOV_REG, 2'd2, `MBBD_CYC_4);
         end
         [8'h78:8'h7f]: begin
            d = mk(MBBD_OP_MOV_REG, 2'd2, `MBBD_CYC_2);
         end
         8'h85: begin
            d = mk(MBBD_OP_MOV_DIR, 2'd3, `MBBD_CYC_4);
         end
         [8'h88:8'h8f]: begin
            d = mk(MBBD_OP_MOV_DIR, 2'd2, `MBBD_CYC_3);
         end
         8'hf5: begin
            d = mk(MBBD_OP_MOV_DIR, 2'd2, `MBBD_CYC_3);
         end
         [8'h86:8'h87]: begin
            d = mk(MBBD_OP_MOV_DIR, 2'd2, `MBBD_CYC_4);
         end
         8'h75: begin
            d = mk(MBBD_OP_MOV_DIR, 2'd3, `MBBD_CYC_3);
         end
         [8'hf6:8'hf7]: begin
            d = mk(MBBD_OP_MOV_IND, 2'd1, `MBBD_CYC_3);
         end
         [8'ha6:8'ha7]: begin
            d = mk(MBBD_OP_MOV_IND, 2'd2, `MBBD_CYC_5);
         end
         [8'h76:8'h77]: begin
            d = mk(MBBD_OP_MOV_IND, 2'd2, `MBBD_CYC_3);
         end
         8'h90: begin
            d = mk(MBBD_OP_LOAD_DATA_POINTER, 2'd3, `MBBD_CYC_3);
         end
         8'h93: begin
            d = mk(MBBD_OP_CODE_LOAD, 2'd1, `MBBD_CYC_3);
         end
         8'h83: begin
            d = mk(MBBD_OP_CODE_LOAD, 2'd1, `MBBD_CYC_3);
         end
         [8'he2:8'he3]: begin
            d = mk(MBBD_OP_EXT_READ, 2'd1, `MBBD_CYC_4);
         end
         8'he0: begin
            d = mk(MBBD_OP_EXT_READ, 2'd1, `MBBD_CYC_4);
         end
         [8'hf2:8'hf3]: begin
            d = mk(MBBD_OP_EXT_WRITE, 2'd1, `MBBD_CYC_5);
         end
         8'hf0: begin
            d = mk(MBBD_OP_EXT_WRITE, 2'd1, `MBBD_CYC_5);
         end
         8'hc0: begin
            d = mk(MBBD_OP_PUSH, 2'd2, `MBBD_CYC_4);
         end
         8'hd0: begin
            d = mk(MBBD_OP_POP, 2'd2, `MBBD_CYC_3);
         end
         [8'hc8:8'hcf]: begin
            d = mk(MBBD_OP_XCH, 2'd1, `MBBD_CYC_2);
         end
         8'hc5: begin
            d = mk(MBBD_OP_XCH, 2'd2, `MBBD_CYC_3);
         end
         [8'hc6:8'hc7]: begin
            d = mk(MBBD_OP_XCH, 2'd1, `MBBD_CYC_3);
         end
         [8'hd6:8'hd7]: begin
            d = mk(MBBD_OP_NIBBLE_XCH, 2'd1, `MBBD_CYC_3);
         end
         default: begin
            d.known = 1'b0;
         end
      endcase
      return d;
   endfunction : dec_move

   // program branch group; the call and jump rows share low bits with no other code
   function automatic mbbd_dec_type dec_branch(input logic [7:0] o);
      mbbd_dec_type d;
      d = '0;
      unique case (o) inside
         8'b???10001: begin
            d = mk(MBBD_OP_CALL, 2'd2, `MBBD_CYC_6);
         end
         8'h12: begin
            d = mk(MBBD_OP_CALL, 2'd3, `MBBD_CYC_6);
         end
         8'b???00001: begin
            d = mk(MBBD_OP_JUMP, 2'd2, `MBBD_CYC_3);
         end
         8'h02: begin
            d = mk(MBBD_OP_JUMP, 2'd3, `MBBD_CYC_4);
         end
         8'h80: begin
            d = mk(MBBD_OP_JUMP, 2'd2, `MBBD_CYC_3);
         end
         8'h73: begin
            d = mk(MBBD_OP_JUMP_IND, 2'd1, `MBBD_CYC_2);
         end
         8'h60: begin
            d = mk(MBBD_OP_COND_BR, 2'd2, `MBBD_CYC_3);
         end
         8'h70: begin
            d = mk(MBBD_OP_COND_BR, 2'd2, `MBBD_CYC_3);
         end
         8'h40: begin
            d = mk(MBBD_OP_COND_BR, 2'd2, `MBBD_CYC_3);
         end
         8'h50: begin
            d = mk(MBBD_OP_COND_BR, 2'd2, `MBBD_CYC_3);
         end
         8'h20: begin
            d = mk(MBBD_OP_BIT_BR, 2'd3, `MBBD_CYC_4);
         end
         8'h30: begin
            d = mk(MBBD_OP_BIT_BR, 2'd3, `MBBD_CYC_4);
         end
         8'h10: begin
            d = mk(MBBD_OP_BIT_BR, 2'd3, `MBBD_CYC_4);
         end
         8'hb5: begin
            d = mk(MBBD_OP_CMP_BR, 2'd3, `MBBD_CYC_4);
         end
         8'hb4: begin
            d = mk(MBBD_OP_CMP_BR, 2'd3, `MBBD_CYC_4);
         end
         [8'hb8:8'hbf]: begin
            d = mk(MBBD_OP_CMP_BR, 2'd3, `MBBD_CYC_4);
         end
         [8'hb6:8'hb7]: begin
            d = mk(MBBD_OP_CMP_BR, 2'd3, `MBBD_CYC_4);
         end
         [8'hd8:8'hdf]: begin
            d = mk(MBBD_OP_DEC_BR, 2'd2, `MBBD_CYC_3);
         end
         8'hd5: begin
            d = mk(MBBD_OP_DEC_BR, 2'd3, `MBBD_CYC_4);
         end
         8'h00: begin
            d = mk(MBBD_OP_NOP, 2'd1, `MBBD_CYC_1);
         end
         default: begin
            d.known = 1'b0;
         end
      endcase
      return d;
   endfunction : dec_branch

   // boolean group
   function automatic mbbd_dec_type dec_bool(input logic [7:0] o);
      mbbd_dec_type d;
      d = '0;
      unique case (o) inside
         8'hc3: begin
            d = mk(MBBD_OP_CARRY_OP, 2'd1, `MBBD_CYC_1);
         end
         8'hd3: begin
            d = mk(MBBD_OP_CARRY_OP, 2'd1, `MBBD_CYC_1);
         end
         8'hb3: begin
            d = mk(MBBD_OP_CARRY_OP, 2'd1, `MBBD_CYC_1);
         end
         8'hc2: begin
            d = mk(MBBD_OP_BIT_OP, 2'd2, `MBBD_CYC_3);
         end
         8'hd2: begin
            d = mk(MBBD_OP_BIT_OP, 2'd2, `MBBD_CYC_3);
         end
         8'hb2: begin
            d = mk(MBBD_OP_BIT_OP, 2'd2, `MBBD_CYC_3);
         end
         8'h82: begin
            d = mk(MBBD_OP_BIT_LOGIC, 2'd2, `MBBD_CYC_2);
         end
         8'h72: begin
            d = mk(MBBD_OP_BIT_LOGIC, 2'd2, `MBBD_CYC_2);
         end
         8'hb0: begin
            d = mk(MBBD_OP_BIT_LOGIC, 2'd2, `MBBD_CYC_2);
         end
         8'ha0: begin
            d = mk(MBBD_OP_BIT_LOGIC, 2'd2, `MBBD_CYC_2);
         end
         8'ha2: begin
            d = mk(MBBD_OP_BIT_MOVE, 2'd2, `MBBD_CYC_2);
         end
         8'h92: begin
            d = mk(MBBD_OP_BIT_MOVE, 2'd2, `MBBD_CYC_3);
         end
         default: begin
            d.known = 1'b0;
         end
      endcase
      return d;
   endfunction : dec_bool

   // groups are disjoint, so the first group that claims a code decides it
   function automatic mbbd_dec_type decode(input logic [7:0] o, input logic pws);
      mbbd_dec_type d;
      d = dec_move(o);
      if (!d.known) begin
         d = dec_branch(o);
      end
      if (!d.known) begin
         d = dec_bool(o);
      end
      // the select bit only steers external moves; its meaning lives elsewhere
      if (d.op_class == MBBD_OP_EXT_READ || d.op_class == MBBD_OP_EXT_WRITE) begin
         d.ext_move = 1'b1;
         d.ext_alt = pws;
      end
      return d;
   endfunction : decode

   ////////////////////////////////////////////////////////////////
   mbbd_state_type state_r, state_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   mbbd_dec_type dec_r, dec_nxt;
   logic done_r, done_nxt;
   mbbd_dec_type dec_now;

   assign dec_now = decode(opc, power_ctrl[`MBBD_PWS_BIT]);

   // unknown opcodes are treated as one cycle so the core never hangs
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      dec_nxt = dec_r;
      done_nxt = 1'b0;
      unique case (state_r)
         MBBD_ST_FETCH: begin
            if (opc_valid) begin
               dec_nxt = dec_now;
               if (!dec_now.known || dec_now.cycles <= 3'd1) begin
                  done_nxt = 1'b1;
               end else begin
                  cnt_nxt = dec_now.cycles - 3'd1;
                  state_nxt = MBBD_ST_EXEC;
               end
            end
         end
         MBBD_ST_EXEC: begin
            cnt_nxt = cnt_r - 3'd1;
            if (cnt_r == 3'd1) begin
               done_nxt = 1'b1;
               state_nxt = MBBD_ST_FETCH;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= MBBD_ST_FETCH;
         cnt_r <= 3'h0;
         dec_r <= '0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         dec_r <= dec_nxt;
         done_r <= done_nxt;
      end
   end

   assign fetch_ready = (state_r == MBBD_ST_FETCH);
   assign instr_done = done_r;
   assign dec_out = dec_r;
   assign cycle_left = cnt_r;
endmodule : mbbd_decoder
`default_nettype wire

/* tb/mbbd_decoder_props.sv */
// assertions for the move, branch and bit decoder
`timescale 1ns/100ps
`default_nettype none
module mbbd_decoder_props
   import mbbd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic opc_valid,
   input wire logic [7:0] opc,
   input wire logic [7:0] power_ctrl,
   input wire logic fetch_ready,
   input wire logic instr_done,
   input wire mbbd_dec_type dec_out,
   input wire logic [2:0] cycle_left
);
   wire logic take = fetch_ready && opc_valid;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_dir_move: assert property (take && opc == 8'h85 |=>
      dec_out.bytes == 2'h3 ##3 instr_done) else $error("bad 85");
   a_ind_busy: assert property (take && opc == 8'ha6 |=> !fetch_ready [*4] ##1 fetch_ready)
      else $error("bad a6");
   a_call_len: assert property (take && opc[4:0] == 5'h11 |=>
      dec_out.cycles == 3'h6 ##5 instr_done) else $error("bad call");
   a_nop_done: assert property (take && opc == 8'h00 |=> instr_done && fetch_ready)
      else $error("bad nop");
   a_ext_sel: assert property (take && opc == 8'hf0 |=>
      dec_out.ext_alt == $past(power_ctrl[4])) else $error("bad select");
   a_ext_class: assert property (take && opc == 8'he2 |=>
      dec_out.op_class == MBBD_OP_EXT_READ) else $error("bad read class");
   a_bit_class: assert property (take && opc == 8'h10 |=>
      dec_out.op_class == MBBD_OP_BIT_BR) else $error("bad bit branch class");
   a_busy_hold: assert property (!fetch_ready |=> $stable(dec_out))
      else $error("decode moved");
   a_left_step: assert property (cycle_left != 3'h0 |=>
      cycle_left == $past(cycle_left) - 3'h1) else $error("bad count");
   a_ready_done: assert property ($rose(fetch_ready) |-> instr_done)
      else $error("no done");
   c_long: cover property (take && opc == 8'h85);
   c_call: cover property (take && opc[4:0] == 5'h11);
   c_ext: cover property (take && opc == 8'hf0 && power_ctrl[4]);
endmodule : mbbd_decoder_props
bind mbbd_decoder mbbd_decoder_props mbbd_decoder_props_inst (.sys_clk(sys_clk), .nrst(nrst),
   .opc_valid(opc_valid), .opc(opc), .power_ctrl(power_ctrl), .fetch_ready(fetch_ready),
   .instr_done(instr_done), .dec_out(dec_out), .cycle_left(cycle_left));
`default_nettype wire

/* tb/mbbd_prog_mem.sv */
// program memory model feeding opcodes to the decoder
`timescale 1ns/100ps
`default_nettype none
module mbbd_prog_mem (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic fetch_ready,
   input wire logic slow,
   output logic [7:0] opc,
   output logic opc_valid
);
   // a held opcode waits for fetch_ready, so refused cycles see a live request
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         opc_valid <= 1'b0;
         opc <= 8'h00;
      end else if (!opc_valid || fetch_ready) begin
         opc_valid <= !slow || ($urandom_range(1) != 0);
         opc <= 8'($urandom);
      end
   end
endmodule : mbbd_prog_mem
`default_nettype wire

/* tb/tb_mbbd_decoder.sv */
// self-checking bench for the move, branch and bit decoder
`timescale 1ns/100ps
`default_nettype none
module tb_mbbd_decoder;
   import mbbd_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic slow = 1'b0;
   logic alt = 1'b0;
   logic [7:0] power_ctrl = 8'h00;
   logic [7:0] due = 8'h00;
   logic [5:0] pend = 6'h00;
   logic opc_valid, fetch_ready, instr_done;
   logic [7:0] opc;
   logic [2:0] cycle_left;
   mbbd_dec_type dec_out;
   int n_errors = 0;
   int total_checks = 0;
   int busy = 0;
   mbbd_decoder mbbd_decoder_inst (.sys_clk(sys_clk), .nrst(nrst), .opc_valid(opc_valid),
      .opc(opc), .power_ctrl(power_ctrl), .fetch_ready(fetch_ready), .instr_done(instr_done),
      .dec_out(dec_out), .cycle_left(cycle_left));
   mbbd_prog_mem mbbd_prog_mem_inst (.sys_clk(sys_clk), .nrst(nrst), .fetch_ready(fetch_ready),
      .slow(slow), .opc(opc), .opc_valid(opc_valid));
   // packs known, bytes and cycles; unlisted codes run one cycle
   function automatic logic [5:0] exp_len(input logic [7:0] o);
      if (o[3:0] == 4'h1) return o[4] ? 6'h36 : 6'h33;
      case (o) inside
         [8'he8:8'hef], 8'h00, 8'hc3, 8'hd3, 8'hb3: return 6'h29;
         8'he6, 8'he7, 8'h73, [8'hf8:8'hff], [8'hc8:8'hcf]: return 6'h2a;
         8'h93, 8'h83, 8'hf6, 8'hf7, 8'hc6, 8'hc7, 8'hd6, 8'hd7: return 6'h2b;
         8'he0, 8'he2, 8'he3: return 6'h2c;
         8'hf0, 8'hf2, 8'hf3: return 6'h2d;
         8'h74, 8'he5, [8'h78:8'h7f], 8'h82, 8'h72, 8'hb0, 8'ha0, 8'ha2: return 6'h32;
         [8'h88:8'h8f], [8'hd8:8'hdf], 8'hf5, 8'hd0, 8'hc5, 8'h80, 8'h60, 8'h70, 8'h40, 8'h50,
            8'hc2, 8'hd2, 8'hb2, 8'h92, 8'h76, 8'h77: return 6'h33;
         [8'ha8:8'haf], 8'h86, 8'h87, 8'hc0: return 6'h34;
         8'ha6, 8'ha7: return 6'h35;
         8'h75, 8'h90: return 6'h3b;
         [8'hb4:8'hbf], 8'h85, 8'h02, 8'h20, 8'h30, 8'h10, 8'hd5: return 6'h3c;
         8'h12: return 6'h3e;
         default: return 6'h01;
      endcase
   endfunction : exp_len
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // reads at the edge see the values settled by the previous edge
   always @(posedge sys_clk) begin
      power_ctrl <= 8'($urandom);
      if (!nrst) begin
         busy = 0;
         due = 8'h00;
         pend = 6'h00;
      end else begin
         chk(8'(instr_done), 8'(due[0]));
         chk(8'(fetch_ready), 8'(busy == 0));
         chk(8'(cycle_left), 8'(busy));
         if (pend != 6'h00) begin
            chk(8'(dec_out.known), 8'(pend[5]));
            if (pend[5]) chk(8'({dec_out.bytes, dec_out.cycles}), 8'(pend[4:0]));
            chk(8'(dec_out.ext_move), 8'(pend[5:1] == 5'h16));
            if (pend[5:1] == 5'h16) chk(8'(dec_out.ext_alt), 8'(alt));
         end
         due = due >> 1;
         pend = 6'h00;
         if (busy > 0) busy--;
         if (fetch_ready && opc_valid) begin
            pend = exp_len(opc);
            alt = power_ctrl[4];
            due[pend[2:0] - 3'h1] = 1'b1;
            busy = pend[2:0] - 3'h1;
         end
      end
   end
   initial begin
      void'($urandom(32'h32f85683));
      repeat (16) @(posedge sys_clk);
      for (int p = 0; p < 3; p++) begin
         nrst <= 1'b1;
         slow <= p[0];
         repeat (2500) @(posedge sys_clk);
         nrst <= 1'b0;
         @(posedge sys_clk);
         $display("test %0d done", p);
      end
      stop_test;
   end
   initial begin
      #100000;
      n_errors++;
      stop_test;
   end
endmodule : tb_mbbd_decoder
`default_nettype wire
